// ==== rtl/tpd_regs.svh ====
`ifndef TPD_REGS_SVH
`define TPD_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TPD_OFF_POWER 6'h00
`define TPD_OFF_PRESC 6'h04
`define TPD_OFF_CTRL 6'h08
`define TPD_OFF_CFG 6'h0c
`define TPD_OFF_MODE 6'h10
`define TPD_OFF_TRIG 6'h14
`define TPD_OFF_DATA_M 6'h18
`define TPD_OFF_DATA_P 6'h1c
`define TPD_OFF_DATA_Q 6'h20
`define TPD_OFF_CNT_M 6'h24
`define TPD_OFF_CNT_P 6'h28
`define TPD_OFF_CNT_Q 6'h2c
`define TPD_OFF_STATUS 6'h30
`define TPD_OFF_PORT 6'h34

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TPD_PWR_UNIT 0
`define TPD_PWR_PRE 1
`define TPD_PRE_A 0
`define TPD_PRE_B 4
`define TPD_CTRL_OE 0
`define TPD_CTRL_LV 4
`define TPD_CFG_POL 8
`define TPD_MODE_CLKB 0
`define TPD_MODE_STINT 1
`define TPD_MODE_GRP 2
`define TPD_TRIG_START 0
`define TPD_TRIG_STOP 8
`define TPD_PORT_DATA 0
`define TPD_PORT_DIR 8

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define TPD_RST_CFG 32'h0000_0000
`define TPD_RST_DATA 16'h0000
`define TPD_CNT_DUTY_EVT 16'h0001
`define TPD_CNT_ZERO 16'h0000
`define TPD_CNT_MAX 16'hffff

`endif

// ==== rtl/tpd_pkg.sv ====
package tpd_pkg;
  typedef enum logic [2:0] {
    TPD_IDLE = 3'b001,
    TPD_LOAD = 3'b010,
    TPD_RUN = 3'b100
  } tpd_phase_t;
  typedef logic [15:0] tpd_count_t;
endpackage : tpd_pkg

// ==== rtl/tpd_prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none
module tpd_prescaler (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Control
  input wire logic i_run,
  input wire logic [3:0] i_sel_a,
  input wire logic [3:0] i_sel_b,
  input wire logic i_use_b,
  // Count clock enable
  output logic o_tick
);
  logic [14:0] cnt;
  logic [14:0] next_cnt;
  logic [15:0] ones;
  logic next_tick;

  // Tick every 2**sel cycles: low bits of the counter all ones
  assign ones[0] = 1'b1;
  genvar g;
  generate
    for (g = 0; g < 15; g++) begin : g_ones
      assign ones[g+1] = ones[g] & cnt[g];
    end
  endgenerate

  always_comb begin
    next_cnt = i_run ? cnt + 15'h0001 : 15'h0000;
    next_tick = i_run & ones[i_use_b ? i_sel_b : i_sel_a];
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt <= 15'h0000;
      o_tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      o_tick <= next_tick;
    end
  end
endmodule : tpd_prescaler
`default_nettype wire

// ==== rtl/tpd_top.sv ====
// The Avalon-MM slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tpd_regs.svh"
module tpd_top
  import tpd_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Avalon-MM slave
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Timer pins, channels 00/02/03 then 04/06/07
  output logic [5:0] o_pin_out,
  output logic [5:0] o_pin_oe,
  // Channel interrupts, one-cycle pulses
  output logic o_master_irq,
  output logic o_duty_irq,
  output logic o_deadtime_irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [1:0] pwr, next_pwr;
  logic [7:0] presc, next_presc;
  logic [2:0] oe, next_oe;
  logic [2:0] lv, next_lv;
  logic [31:0] cfg, next_cfg;
  logic [2:0] mode, next_mode;
  logic [5:0] port_data, next_port_data;
  logic [5:0] port_dir, next_port_dir;
  tpd_count_t dat_m, dat_p, dat_q, next_dat_m, next_dat_p, next_dat_q;
  tpd_count_t cnt_m, cnt_p, cnt_q, next_cnt_m, next_cnt_p, next_cnt_q;
  logic [2:0] en, next_en;
  tpd_phase_t ph_m, ph_p, next_ph_m, next_ph_p;
  logic up, next_up;
  logic run_q, next_run_q;
  logic pdn, next_pdn;
  logic [2:0] irq, next_irq;
  logic [5:0] next_pin_out;
  logic wait_q, next_wait;
  logic [31:0] next_rdata;

  // ----------------------------------------
  // Combinational helpers
  // ----------------------------------------
  logic pwr_on;
  logic tick;
  logic wr_acc;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [2:0] start;
  logic [2:0] stop;
  logic ev_m, ev_p, ev_q;
  logic wrap_m;
  logic [5:0] pin_timer;

  assign pwr_on = pwr[`TPD_PWR_UNIT] & pwr[`TPD_PWR_PRE];
  assign wr_acc = i_avs_write & ~wait_q;
  assign wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                  {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction : merge

  // Count clock stops with power off, so counters cannot move
  tpd_prescaler u_presc (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_run(pwr_on),
    .i_sel_a(presc[`TPD_PRE_A +: 4]),
    .i_sel_b(presc[`TPD_PRE_B +: 4]),
    .i_use_b(mode[`TPD_MODE_CLKB]),
    .o_tick(tick)
  );

  // ----------------------------------------
  // Pin function per placement
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_pin
      localparam logic IS_HIGH = (gi >= 3);
      // Timer level is ORed with port data, so port data must be 0
      assign pin_timer[gi] = (pwr_on && (mode[`TPD_MODE_GRP] == IS_HIGH)) ?
                             (lv[gi % 3] | port_data[gi]) : port_data[gi];
    end
  endgenerate

  // ----------------------------------------
  // Bus handshake: one wait cycle per access
  // ----------------------------------------
  always_comb begin
    next_wait = 1'b1;
    next_rdata = o_avs_readdata;
    if ((i_avs_read | i_avs_write) && wait_q) begin
      next_wait = 1'b0;
    end
    if (i_avs_read && wait_q) begin
      next_rdata = 32'h0000_0000;
      unique case (i_avs_address)
        `TPD_OFF_POWER: next_rdata[1:0] = pwr;
        `TPD_OFF_PRESC: next_rdata[7:0] = presc;
        `TPD_OFF_CTRL: begin
          next_rdata[`TPD_CTRL_OE +: 3] = oe;
          next_rdata[`TPD_CTRL_LV +: 3] = lv;
        end
        `TPD_OFF_CFG: next_rdata = cfg;
        `TPD_OFF_MODE: next_rdata[2:0] = mode;
        `TPD_OFF_TRIG: next_rdata[`TPD_TRIG_START +: 3] = en;
        `TPD_OFF_DATA_M: next_rdata[15:0] = dat_m;
        `TPD_OFF_DATA_P: next_rdata[15:0] = dat_p;
        `TPD_OFF_DATA_Q: next_rdata[15:0] = dat_q;
        `TPD_OFF_CNT_M: next_rdata[15:0] = cnt_m;
        `TPD_OFF_CNT_P: next_rdata[15:0] = cnt_p;
        `TPD_OFF_CNT_Q: next_rdata[15:0] = cnt_q;
        `TPD_OFF_STATUS: next_rdata[0] = up;
        `TPD_OFF_PORT: begin
          next_rdata[`TPD_PORT_DATA +: 6] = port_data;
          next_rdata[`TPD_PORT_DIR +: 6] = port_dir;
        end
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wait_q <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      wait_q <= next_wait;
      o_avs_readdata <= next_rdata;
    end
  end
  assign o_avs_waitrequest = wait_q;

  // ----------------------------------------
  // Registers, counters and outputs
  // ----------------------------------------
  always_comb begin
    next_pwr = pwr;
    next_presc = presc;
    next_oe = oe;
    next_lv = lv;
    next_cfg = cfg;
    next_mode = mode;
    next_port_data = port_data;
    next_port_dir = port_dir;
    next_dat_m = dat_m;
    next_dat_p = dat_p;
    next_dat_q = dat_q;
    next_cnt_m = cnt_m;
    next_cnt_p = cnt_p;
    next_cnt_q = cnt_q;
    next_en = en;
    next_ph_m = ph_m;
    next_ph_p = ph_p;
    next_up = up;
    next_run_q = run_q;
    next_pdn = pdn;
    start = 3'b000;
    stop = 3'b000;
    ev_m = 1'b0;
    ev_p = 1'b0;
    ev_q = 1'b0;
    wrap_m = 1'b0;
    wval = 32'h0000_0000;

    // Register writes
    if (wr_acc) begin
      unique case (i_avs_address)
        `TPD_OFF_POWER: begin
          wval = merge({30'h0, pwr}, i_avs_writedata, wmask);
          next_pwr = wval[1:0];
        end
        `TPD_OFF_PORT: begin
          wval = merge({18'h0, port_dir, 2'b00, port_data}, i_avs_writedata, wmask);
          next_port_data = wval[`TPD_PORT_DATA +: 6];
          next_port_dir = wval[`TPD_PORT_DIR +: 6];
        end
        default: begin
          if (pwr_on) begin
            unique case (i_avs_address)
              `TPD_OFF_PRESC: next_presc = 8'(merge({24'h0, presc}, i_avs_writedata, wmask));
              `TPD_OFF_CTRL: begin
                wval = merge({25'h0, lv, 1'b0, oe}, i_avs_writedata, wmask);
                next_oe = wval[`TPD_CTRL_OE +: 3];
                next_lv = wval[`TPD_CTRL_LV +: 3];
              end
              `TPD_OFF_CFG: next_cfg = merge(cfg, i_avs_writedata, wmask);
              `TPD_OFF_MODE: next_mode = 3'(merge({29'h0, mode}, i_avs_writedata, wmask));
              `TPD_OFF_TRIG: begin
                start = i_avs_writedata[`TPD_TRIG_START +: 3] &
                        {3{i_avs_byteenable[0]}};
                stop = i_avs_writedata[`TPD_TRIG_STOP +: 3] &
                       {3{i_avs_byteenable[1]}};
              end
              `TPD_OFF_DATA_M: next_dat_m = 16'(merge({16'h0, dat_m}, i_avs_writedata, wmask));
              `TPD_OFF_DATA_P: next_dat_p = 16'(merge({16'h0, dat_p}, i_avs_writedata, wmask));
              `TPD_OFF_DATA_Q: next_dat_q = 16'(merge({16'h0, dat_q}, i_avs_writedata, wmask));
              default: next_presc = presc;
            endcase
          end
        end
      endcase
    end

    // Master: interval down counter, carrier half periods
    if (en[0] && tick) begin
      unique case (ph_m)
        TPD_IDLE: next_ph_m = TPD_IDLE;
        TPD_LOAD: begin
          next_cnt_m = dat_m;
          next_ph_m = TPD_RUN;
          next_up = 1'b0;
          ev_m = mode[`TPD_MODE_STINT];
        end
        TPD_RUN: begin
          if (cnt_m == `TPD_CNT_ZERO) begin
            next_cnt_m = dat_m;
            ev_m = 1'b1;
            wrap_m = 1'b1;
            next_up = ~up;
          end else begin
            next_cnt_m = cnt_m - 16'h0001;
          end
        end
      endcase
    end

    // Duty channel follows master status
    if (en[1] && tick) begin
      unique case (ph_p)
        TPD_IDLE: next_ph_p = TPD_IDLE;
        TPD_LOAD: begin
          next_cnt_p = dat_p;
          next_ph_p = TPD_RUN;
        end
        TPD_RUN: begin
          if (wrap_m && up) begin
            next_cnt_p = dat_p;
          end else if (up) begin
            if (cnt_p != `TPD_CNT_MAX) next_cnt_p = cnt_p + 16'h0001;
          end else begin
            if (cnt_p != `TPD_CNT_ZERO) next_cnt_p = cnt_p - 16'h0001;
          end
          ev_p = (next_cnt_p == `TPD_CNT_DUTY_EVT) && (next_cnt_p != cnt_p);
        end
      endcase
      if (ev_p) next_pdn = ~up;
    end

    // Dead-time channel: one-count, retriggered by the duty event
    if (en[2]) begin
      if (irq[1]) begin
        next_cnt_q = dat_q;
        next_run_q = 1'b1;
      end else if (tick && run_q) begin
        if (cnt_q == `TPD_CNT_ZERO) begin
          ev_q = 1'b1;
          next_run_q = 1'b0;
        end else begin
          next_cnt_q = cnt_q - 16'h0001;
        end
      end
    end

    // Output levels, gated by output enable
    if (ev_m && oe[0]) next_lv[0] = ~lv[0];
    if (ev_p && up && oe[1]) next_lv[1] = cfg[`TPD_CFG_POL + 1];
    if (ev_p && !up && oe[2]) next_lv[2] = ~cfg[`TPD_CFG_POL + 2];
    if (ev_q && pdn) begin
      if (oe[1]) next_lv[1] = ~cfg[`TPD_CFG_POL + 1];
      if (oe[2]) next_lv[2] = cfg[`TPD_CFG_POL + 2];
    end

    // Start then stop; stop wins if both land together
    if (|start) begin
      next_en = next_en | start;
      if (start[0]) next_ph_m = TPD_LOAD;
      if (start[1]) next_ph_p = TPD_LOAD;
      if (start[2]) next_run_q = 1'b0;
    end
    if (|stop) begin
      next_en = next_en & ~stop;
      if (stop[0]) next_ph_m = TPD_IDLE;
      if (stop[1]) next_ph_p = TPD_IDLE;
      if (stop[2]) next_run_q = 1'b0;
    end

    // Power off returns every timer register to reset
    if (!pwr_on) begin
      next_presc = 8'h00;
      next_oe = 3'b000;
      next_lv = 3'b000;
      next_cfg = `TPD_RST_CFG;
      next_mode = 3'b000;
      next_dat_m = `TPD_RST_DATA;
      next_dat_p = `TPD_RST_DATA;
      next_dat_q = `TPD_RST_DATA;
      next_cnt_m = `TPD_CNT_ZERO;
      next_cnt_p = `TPD_CNT_ZERO;
      next_cnt_q = `TPD_CNT_ZERO;
      next_en = 3'b000;
      next_ph_m = TPD_IDLE;
      next_ph_p = TPD_IDLE;
      next_up = 1'b0;
      next_run_q = 1'b0;
      next_pdn = 1'b0;
    end

    next_irq = {ev_q, ev_p, ev_m};
    next_pin_out = pin_timer;
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pwr <= 2'b00;
      presc <= 8'h00;
      oe <= 3'b000;
      lv <= 3'b000;
      cfg <= `TPD_RST_CFG;
      mode <= 3'b000;
      port_data <= 6'h00;
      port_dir <= 6'h00;
      dat_m <= `TPD_RST_DATA;
      dat_p <= `TPD_RST_DATA;
      dat_q <= `TPD_RST_DATA;
      cnt_m <= `TPD_CNT_ZERO;
      cnt_p <= `TPD_CNT_ZERO;
      cnt_q <= `TPD_CNT_ZERO;
      en <= 3'b000;
      ph_m <= TPD_IDLE;
      ph_p <= TPD_IDLE;
      up <= 1'b0;
      run_q <= 1'b0;
      pdn <= 1'b0;
      irq <= 3'b000;
      o_pin_out <= 6'h00;
      o_pin_oe <= 6'h00;
    end else begin
      pwr <= next_pwr;
      presc <= next_presc;
      oe <= next_oe;
      lv <= next_lv;
      cfg <= next_cfg;
      mode <= next_mode;
      port_data <= next_port_data;
      port_dir <= next_port_dir;
      dat_m <= next_dat_m;
      dat_p <= next_dat_p;
      dat_q <= next_dat_q;
      cnt_m <= next_cnt_m;
      cnt_p <= next_cnt_p;
      cnt_q <= next_cnt_q;
      en <= next_en;
      ph_m <= next_ph_m;
      ph_p <= next_ph_p;
      up <= next_up;
      run_q <= next_run_q;
      pdn <= next_pdn;
      irq <= next_irq;
      o_pin_out <= next_pin_out;
      o_pin_oe <= next_port_dir;
    end
  end

  assign o_master_irq = irq[0];
  assign o_duty_irq = irq[1];
  assign o_deadtime_irq = irq[2];

endmodule : tpd_top
`default_nettype wire

// ==== verif/tpd_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tpd_regs.svh"
module tpd_properties (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Register bus
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic o_avs_waitrequest,
  // Pins and events
  input wire logic [5:0] o_pin_out,
  input wire logic [5:0] o_pin_oe,
  input wire logic o_master_irq,
  input wire logic o_duty_irq,
  input wire logic o_deadtime_irq
);
  typedef struct packed {
    logic pwr; logic run; logic pend; logic ok; logic [2:0] quiet; logic [2:0] mode;
    logic [7:0] presc; logic [13:0] port; logic [15:0] dm; logic [31:0] gap;
  } tpd_shadow_t;
  tpd_shadow_t sh;
  tpd_shadow_t next_sh;
  logic wr_c;
  logic [31:0] per_exp;

  // ------------
  // Shadow of committed writes
  // ------------
  assign wr_c = i_avs_write && !o_avs_waitrequest;
  assign per_exp = (({16'h0, sh.dm} + 32'h1) <<
                    (sh.mode[0] ? sh.presc[7:4] : sh.presc[3:0])) - 32'h1;
  always_comb begin
    next_sh = sh;
    if (wr_c && i_avs_address == `TPD_OFF_POWER) next_sh.pwr = i_avs_writedata[1:0] == 2'b11;
    if (wr_c && i_avs_address == `TPD_OFF_PORT) next_sh.port = i_avs_writedata[13:0];
    if (wr_c && sh.pwr) begin
      case (i_avs_address)
        `TPD_OFF_PRESC: next_sh.presc = i_avs_writedata[7:0];
        `TPD_OFF_MODE: next_sh.mode = i_avs_writedata[2:0];
        `TPD_OFF_DATA_M: next_sh.dm = i_avs_writedata[15:0];
        `TPD_OFF_TRIG: next_sh.run = (i_avs_writedata[10:8] == 3'h0) &&
                                     (sh.run || i_avs_writedata[2:0] != 3'h0);
        default: ;
      endcase
    end
    next_sh.pend = sh.run && (o_duty_irq || (sh.pend && !o_deadtime_irq));
    // A write may move the period, so gap checks restart after it
    next_sh.ok = sh.run && !wr_c && (sh.ok || o_master_irq);
    next_sh.gap = o_master_irq ? 32'h0 : sh.gap + 32'h1;
    next_sh.quiet = (wr_c || sh.run) ? 3'h0 : sh.quiet + {2'h0, sh.quiet != 3'h7};
    if (!sh.pwr) begin
      next_sh.run = 1'b0;
      next_sh.presc = 8'h0;
      next_sh.mode = 3'h0;
      next_sh.dm = 16'h0;
    end
  end
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sh <= '0;
    end else begin
      sh <= next_sh;
    end
  end

  // ------------
  // Properties
  // ------------
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  wait_answer_a: assert property (
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus request not answered after one cycle");
  wait_single_a: assert property (
    !o_avs_waitrequest |=> o_avs_waitrequest) else $error("waitrequest low too long");
  idle_quiet_a: assert property (
    !sh.run && !$past(sh.run) |-> !o_master_irq && !o_duty_irq && !o_deadtime_irq)
    else $error("interrupt while stopped");
  q_after_p_a: assert property (
    o_deadtime_irq |-> sh.pend) else $error("dead-time event without duty event");
  oe_follow_a: assert property (
    o_pin_oe == sh.port[13:8]) else $error("pin enables differ from port direction");
  off_pins_a: assert property (
    !sh.pwr && !$past(sh.pwr) && !$past(sh.pwr, 2) |-> o_pin_out == $past(sh.port[5:0]))
    else $error("powered-off pins not on port data");
  hold_pins_a: assert property (
    sh.quiet == 3'h7 |-> $stable(o_pin_out)) else $error("pins moved while stopped");
  start_irq_a: assert property (
    wr_c && i_avs_address == `TPD_OFF_TRIG && i_avs_writedata[10:0] == 11'h007 && sh.pwr &&
    !sh.run && sh.mode[1:0] == 2'b10 && sh.presc[3:0] == 4'h0 |-> ##[1:4] o_master_irq)
    else $error("no master event at start");
  period_a: assert property (
    sh.ok && o_master_irq |-> sh.gap == per_exp) else $error("master period wrong");
endmodule : tpd_properties

bind tpd_top tpd_properties u_props (
  .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
  .o_master_irq(o_master_irq), .o_duty_irq(o_duty_irq), .o_deadtime_irq(o_deadtime_irq)
);
`default_nettype wire

// ==== verif/tpd_power_stage.sv ====
`timescale 1ns/1ps
`default_nettype none
module tpd_power_stage (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // Timer pins
  input wire logic [5:0] i_pin_out,
  input wire logic [5:0] i_pin_oe,
  // Gate drive side
  output logic [5:0] o_gate,
  output logic [15:0] o_edges
);
  logic [5:0] last;
  logic [5:0] next_last;
  logic [15:0] next_edges;
  // ------------
  // Gate inputs
  // ------------
  // Released pins fall to the driver's pull-down, never to a stale level
  assign o_gate = i_pin_out & i_pin_oe;
  always_comb begin
    next_last = o_gate;
    next_edges = o_edges + 16'(|((o_gate ^ last) & 6'h36));
  end
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      last <= 6'h0;
      o_edges <= 16'h0;
    end else begin
      last <= next_last;
      o_edges <= next_edges;
    end
  end
endmodule : tpd_power_stage
`default_nettype wire

// ==== verif/test_tpd_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tpd_regs.svh"
module test_tpd_top;
  logic i_clk_sys;
  logic i_sys_rst;
  logic [5:0] i_avs_address;
  logic i_avs_read;
  logic i_avs_write;
  logic [31:0] i_avs_writedata;
  logic [3:0] i_avs_byteenable;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  logic [5:0] o_pin_out;
  logic [5:0] o_pin_oe;
  logic o_master_irq;
  logic o_duty_irq;
  logic o_deadtime_irq;
  logic [5:0] gate;
  logic [15:0] edges;
  logic [15:0] e0;
  logic [2:0] lv;
  logic [63:0] note;
  logic [63:0] exp_q[$];
  int err_count;
  int compares;

  tpd_top DUT (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
    .o_master_irq(o_master_irq), .o_duty_irq(o_duty_irq), .o_deadtime_irq(o_deadtime_irq)
  );
  tpd_power_stage u_stage (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_pin_out(o_pin_out),
    .i_pin_oe(o_pin_oe), .o_gate(gate), .o_edges(edges));

  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  // ------------
  // Bus and checking tasks
  // ------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_avs_address <= a;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    i_avs_writedata <= d;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    if (o_avs_waitrequest !== 1'b0) begin
      err_count++;
      $display("unexpected at %0t: bus access not answered", $time);
    end
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({m, e});
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic settle();
    repeat (3) @(posedge i_clk_sys);
  endtask : settle

  // Read data stand from the edge before the completing one until the next read; checked at the completing edge
  always @(posedge i_clk_sys) begin
    if (i_avs_read && o_avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      chk(o_avs_readdata & note[63:32], note[31:0]);
    end
  end

  task automatic run(input logic [31:0] presc, input logic [31:0] mode, input int sh);
    wr(`TPD_OFF_PRESC, presc);
    wr(`TPD_OFF_CFG, 32'h0000_0466);
    wr(`TPD_OFF_MODE, mode);
    wr(`TPD_OFF_DATA_M, 32'd10);
    wr(`TPD_OFF_DATA_P, 32'd2 + $urandom_range(3));
    wr(`TPD_OFF_DATA_Q, 32'd1 + $urandom_range(1));
    wr(`TPD_OFF_CTRL, 32'h40);
    wr(`TPD_OFF_CTRL, 32'h47);
    settle();
    chk(32'(o_pin_out), 32'h4 << sh);
    e0 = edges;
    wr(`TPD_OFF_TRIG, 32'h7);
    rd(`TPD_OFF_TRIG, 32'h7, 32'h7);
    repeat (300) @(posedge i_clk_sys);
    rd(`TPD_OFF_CNT_M, 32'h0, 32'hffff_fff0);
    rd(`TPD_OFF_CNT_P, 32'h0, 32'hffff_ffc0);
    rd(`TPD_OFF_CNT_Q, 32'h0, 32'hffff_fffc);
    wr(`TPD_OFF_DATA_P, 32'(3'($urandom())));
    repeat (200) @(posedge i_clk_sys);
    chk(32'(edges > e0 + 16'd2), 32'h1);
    wr(`TPD_OFF_TRIG, 32'h700);
    rd(`TPD_OFF_TRIG, 32'h0, 32'h7);
    repeat (20) @(posedge i_clk_sys);
    $display("test run at pin %0d done", sh);
  endtask : run

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    #400000;
    err_count++;
    $display("unexpected at %0t: run did not finish", $time);
    finish_test();
  end

  // ------------
  // Main sequence
  // ------------
  initial begin
    i_sys_rst = 1'b1;
    i_avs_address = 6'h0;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_writedata = 32'h0;
    i_avs_byteenable = 4'hf;
    err_count = 0;
    compares = 0;
    lv = 3'($urandom(32'h26f2));
    repeat (10) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    chk(32'({o_avs_waitrequest, o_pin_oe, o_pin_out}), 32'h1000);
    wr(`TPD_OFF_CTRL, 32'h77);
    rd(`TPD_OFF_CTRL, 32'h0, 32'hffff_ffff);
    $display("test powered-off writes done");
    wr(`TPD_OFF_POWER, 32'h3);
    rd(`TPD_OFF_TRIG, 32'h0, 32'h7);
    wr(`TPD_OFF_PORT, 32'h3f00);
    for (int i = 0; i < 8; i++) begin
      wr(`TPD_OFF_CTRL, 32'(i) << 4);
      settle();
      chk(32'(o_pin_out), 32'(i));
    end
    chk(32'(o_pin_oe), 32'h3f);
    wr(6'h3c, $urandom());
    rd(6'h3c, 32'h0, 32'hffff_ffff);
    $display("test levels done");
    run(32'h0, 32'h2, 0);
    wr(`TPD_OFF_CTRL, 32'(lv) << 4);
    settle();
    chk(32'(gate), 32'(lv));
    wr(`TPD_OFF_PORT, 32'h3f15);
    wr(`TPD_OFF_POWER, 32'h0);
    settle();
    chk(32'(o_pin_out), 32'h15);
    rd(`TPD_OFF_CTRL, 32'h0, 32'hffff_ffff);
    rd(`TPD_OFF_PORT, 32'h3f15, 32'hffff_ffff);
    wr(`TPD_OFF_PORT, 32'h0);
    settle();
    chk(32'(gate), 32'h0);
    $display("test power-off done");
    wr(`TPD_OFF_POWER, 32'h3);
    wr(`TPD_OFF_PORT, 32'h3f00);
    run(32'h13, 32'h7, 3);
    finish_test();
  end
endmodule : test_tpd_top
`default_nettype wire
